/* common/cdi_map.svh */
`ifndef CDI_MAP_SVH
`define CDI_MAP_SVH

// Register offsets
`define CDI_OFS_DRIVE_CHAN2 8'h20
`define CDI_OFS_DRIVE_CHAN3 8'h21
`define CDI_OFS_MAKER_CODE  8'h7E
`define CDI_OFS_PART_CODE   8'h7F

// Excitation level field
`define CDI_LEVEL_MSB 15
`define CDI_LEVEL_LSB 11
`define CDI_LEVEL_RST 5'h00

// Target port
`define CDI_I2C_ADDR  7'h2A
`define CDI_BYTE_BITS 4'h8

`endif

/* common/cdi_pkg.sv */
package cdi_pkg;

    typedef logic [4:0] cdi_level_t;

    typedef enum logic [2:0] {
        CDI_ST_IDLE = 3'b000,
        CDI_ST_ADDR = 3'b001,
        CDI_ST_PTR  = 3'b010,
        CDI_ST_WDAT = 3'b011,
        CDI_ST_RDAT = 3'b100,
        CDI_ST_ACK  = 3'b101,
        CDI_ST_RACK = 3'b110
    } cdi_i2c_st_e;

    typedef enum logic {
        CDI_MODE_SLEEP  = 1'b0,
        CDI_MODE_ACTIVE = 1'b1
    } cdi_mode_e;

endpackage

/* verilog/cdi_regs.sv */
// Operation
// - Channel 2 excitation level in bits 15:11, reset zero, applied during settle and convert.
// - Channel 3 excitation level in bits 15:11, reset zero, same mapping, lower bits reserved.
// - Read-only 16-bit maker code at 0x7E; writes leave it unchanged.
// - Read-only part code at 0x7F, one value per resolution variant.
// - Sleep keeps every register value intact.
// - Shutdown returns registers to reset; host reprograms afterwards.
// - Device powers up asleep, converting nothing until commanded active.
`timescale 1ns/1ps
`include "cdi_map.svh"

module cdi_regs #(
    parameter logic [15:0] MAKER_CODE  = 16'hA5C3, // Arbitrary value
    parameter logic [15:0] PART_CODE_N = 16'h0101, // Arbitrary value
    parameter logic [15:0] PART_CODE_W = 16'h0102, // Arbitrary value
    parameter bit          WIDE_PART   = 1'b0
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              RST_I,
    input  wire logic              CE_I,
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE_O,
    input  wire logic              SHUTDOWN_I,
    input  wire logic              ACTIVE_CMD_I,
    input  wire logic              CH2_BUSY_I,
    input  wire logic              CH3_BUSY_I,
    output cdi_pkg::cdi_level_t    CH2_LEVEL_O,
    output cdi_pkg::cdi_level_t    CH3_LEVEL_O,
    output logic                   CH2_DRIVE_EN_O,
    output logic                   CH3_DRIVE_EN_O,
    output logic                   CONV_EN_O
);
    import cdi_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Register read decode

    function automatic logic [15:0] read_word(input logic [7:0] ofs, input cdi_level_t l2, input cdi_level_t l3);
        logic [15:0] w;
        w = 16'h0000;
        unique case (ofs)
            `CDI_OFS_DRIVE_CHAN2: w[`CDI_LEVEL_MSB:`CDI_LEVEL_LSB] = l2;
            `CDI_OFS_DRIVE_CHAN3: w[`CDI_LEVEL_MSB:`CDI_LEVEL_LSB] = l3;
            `CDI_OFS_MAKER_CODE:  w = MAKER_CODE;
            `CDI_OFS_PART_CODE:   w = WIDE_PART ? PART_CODE_W : PART_CODE_N;
            default:              w = 16'h0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    cdi_i2c_st_e st_r, st_nxt, tgt_r, tgt_nxt;
    cdi_mode_e   mode_r, mode_nxt;
    cdi_level_t  lvl2_r, lvl2_nxt, lvl3_r, lvl3_nxt;
    logic [7:0]  sh_r, sh_nxt, hi_r, hi_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic        hi_sel_r, hi_sel_nxt, oe_r, oe_nxt;
    logic        scl_q_r, sda_q_r;
    logic        scl_rise, scl_fall, bus_start, bus_stop;
    logic        wr_stb;
    logic [15:0] wr_word, rd_word;

    assign scl_rise  = SCL_I & ~scl_q_r;
    assign scl_fall  = ~SCL_I & scl_q_r;
    assign bus_start = SCL_I & scl_q_r & sda_q_r & ~SDA_I;
    assign bus_stop  = SCL_I & scl_q_r & ~sda_q_r & SDA_I;
    assign rd_word   = read_word(ptr_r, lvl2_r, lvl3_r);

    always_comb begin
        st_nxt     = st_r;
        tgt_nxt    = tgt_r;
        mode_nxt   = mode_r;
        lvl2_nxt   = lvl2_r;
        lvl3_nxt   = lvl3_r;
        sh_nxt     = sh_r;
        hi_nxt     = hi_r;
        tx_nxt     = tx_r;
        ptr_nxt    = ptr_r;
        cnt_nxt    = cnt_r;
        hi_sel_nxt = hi_sel_r;
        oe_nxt     = oe_r;
        wr_stb     = 1'b0;
        wr_word    = {hi_r, sh_r};
        if (SHUTDOWN_I) begin
            // Configuration lost, port dormant
            st_nxt   = CDI_ST_IDLE;
            oe_nxt   = 1'b0;
            mode_nxt = CDI_MODE_SLEEP;
            lvl2_nxt = `CDI_LEVEL_RST;
            lvl3_nxt = `CDI_LEVEL_RST;
            ptr_nxt  = 8'h00;
        end else begin
            mode_nxt = ACTIVE_CMD_I ? CDI_MODE_ACTIVE : CDI_MODE_SLEEP;
            if (bus_start) begin
                st_nxt     = CDI_ST_ADDR;
                cnt_nxt    = 4'h0;
                oe_nxt     = 1'b0;
                hi_sel_nxt = 1'b0;
            end else if (bus_stop) begin
                st_nxt = CDI_ST_IDLE;
                oe_nxt = 1'b0;
            end else begin
                unique case (st_r)
                    CDI_ST_IDLE: begin
                        oe_nxt = 1'b0;
                    end
                    CDI_ST_ADDR, CDI_ST_PTR, CDI_ST_WDAT: begin
                        if (scl_rise) begin
                            sh_nxt  = {sh_r[6:0], SDA_I};
                            cnt_nxt = cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == `CDI_BYTE_BITS) begin
                            cnt_nxt = 4'h0;
                            oe_nxt  = 1'b1;
                            st_nxt  = CDI_ST_ACK;
                            if (st_r == CDI_ST_ADDR) begin
                                tgt_nxt = sh_r[0] ? CDI_ST_RDAT : CDI_ST_PTR;
                                if (sh_r[7:1] != `CDI_I2C_ADDR) begin
                                    oe_nxt = 1'b0;
                                    st_nxt = CDI_ST_IDLE;
                                end
                            end else if (st_r == CDI_ST_PTR) begin
                                ptr_nxt    = sh_r;
                                tgt_nxt    = CDI_ST_WDAT;
                                hi_sel_nxt = 1'b0;
                            end else begin
                                tgt_nxt = CDI_ST_WDAT;
                                if (!hi_sel_r) begin
                                    hi_nxt     = sh_r;
                                    hi_sel_nxt = 1'b1;
                                end else begin
                                    wr_stb     = 1'b1;
                                    hi_sel_nxt = 1'b0;
                                    ptr_nxt    = ptr_r + 8'h01;
                                end
                            end
                        end
                    end
                    CDI_ST_ACK: begin
                        if (scl_fall) begin
                            st_nxt = tgt_r;
                            oe_nxt = 1'b0;
                            if (tgt_r == CDI_ST_RDAT) begin
                                tx_nxt     = rd_word[15:8];
                                oe_nxt     = ~rd_word[15];
                                hi_sel_nxt = 1'b1;
                            end
                        end
                    end
                    CDI_ST_RDAT: begin
                        if (scl_rise) begin
                            cnt_nxt = cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == `CDI_BYTE_BITS) begin
                                cnt_nxt = 4'h0;
                                oe_nxt  = 1'b0;
                                st_nxt  = CDI_ST_RACK;
                            end else begin
                                tx_nxt = {tx_r[6:0], 1'b0};
                                oe_nxt = ~tx_r[6];
                            end
                        end
                    end
                    CDI_ST_RACK: begin
                        if (scl_rise && SDA_I) begin
                            st_nxt = CDI_ST_IDLE;
                        end else if (scl_fall) begin
                            st_nxt = CDI_ST_RDAT;
                            if (hi_sel_r) begin
                                tx_nxt     = rd_word[7:0];
                                oe_nxt     = ~rd_word[7];
                                hi_sel_nxt = 1'b0;
                                ptr_nxt    = ptr_r + 8'h01;
                            end else begin
                                tx_nxt     = rd_word[15:8];
                                oe_nxt     = ~rd_word[15];
                                hi_sel_nxt = 1'b1;
                            end
                        end
                    end
                    default: begin
                        st_nxt = CDI_ST_IDLE;
                        oe_nxt = 1'b0;
                    end
                endcase
            end
            // Writes land only in the level fields; identity words ignore them
            if (wr_stb && ptr_r == `CDI_OFS_DRIVE_CHAN2) begin
                lvl2_nxt = wr_word[`CDI_LEVEL_MSB:`CDI_LEVEL_LSB];
            end
            if (wr_stb && ptr_r == `CDI_OFS_DRIVE_CHAN3) begin
                lvl3_nxt = wr_word[`CDI_LEVEL_MSB:`CDI_LEVEL_LSB];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            st_r     <= CDI_ST_IDLE;
            tgt_r    <= CDI_ST_IDLE;
            mode_r   <= CDI_MODE_SLEEP;
            lvl2_r   <= `CDI_LEVEL_RST;
            lvl3_r   <= `CDI_LEVEL_RST;
            sh_r     <= 8'h00;
            hi_r     <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= 8'h00;
            cnt_r    <= 4'h0;
            hi_sel_r <= 1'b0;
            oe_r     <= 1'b0;
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
        end else if (CE_I) begin
            st_r     <= st_nxt;
            tgt_r    <= tgt_nxt;
            mode_r   <= mode_nxt;
            lvl2_r   <= lvl2_nxt;
            lvl3_r   <= lvl3_nxt;
            sh_r     <= sh_nxt;
            hi_r     <= hi_nxt;
            tx_r     <= tx_nxt;
            ptr_r    <= ptr_nxt;
            cnt_r    <= cnt_nxt;
            hi_sel_r <= hi_sel_nxt;
            oe_r     <= oe_nxt;
            scl_q_r  <= SCL_I;
            sda_q_r  <= SDA_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SDA_O          = 1'b0;
    assign SDA_OE_O       = oe_r;
    assign CH2_LEVEL_O    = lvl2_r;
    assign CH3_LEVEL_O    = lvl3_r;
    assign CONV_EN_O      = (mode_r == CDI_MODE_ACTIVE);
    assign CH2_DRIVE_EN_O = CH2_BUSY_I & CONV_EN_O;
    assign CH3_DRIVE_EN_O = CH3_BUSY_I & CONV_EN_O;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic ld_first;
    assign ld_first = CE_I & ~SHUTDOWN_I & ~bus_start & ~bus_stop & scl_fall
                    & (st_r == CDI_ST_ACK) & (tgt_r == CDI_ST_RDAT);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    property p_lvl2_write;
        (CE_I && wr_stb && !SHUTDOWN_I && ptr_r == `CDI_OFS_DRIVE_CHAN2)
            |=> (CH2_LEVEL_O == $past(wr_word[15:11])) && $stable(CH3_LEVEL_O);
    endproperty
    a_lvl2_write: assert property (p_lvl2_write) else $error("Channel 2 level not written");

    property p_lvl3_write;
        (CE_I && wr_stb && !SHUTDOWN_I && ptr_r == `CDI_OFS_DRIVE_CHAN3)
            |=> (CH3_LEVEL_O == $past(wr_word[15:11])) && $stable(CH2_LEVEL_O);
    endproperty
    a_lvl3_write: assert property (p_lvl3_write) else $error("Channel 3 level not written");

    property p_maker_read;
        (ld_first && ptr_r == `CDI_OFS_MAKER_CODE) |=> (tx_r == MAKER_CODE[15:8]) && (SDA_OE_O == ~MAKER_CODE[15]);
    endproperty
    a_maker_read: assert property (p_maker_read) else $error("Maker code high byte wrong");

    property p_part_read;
        (ld_first && ptr_r == `CDI_OFS_PART_CODE)
            |=> tx_r == (WIDE_PART ? PART_CODE_W[15:8] : PART_CODE_N[15:8]);
    endproperty
    a_part_read: assert property (p_part_read) else $error("Part code high byte wrong");

    property p_sleep_keeps;
        (mode_r == CDI_MODE_SLEEP && !SHUTDOWN_I && !wr_stb)
            |=> $stable(CH2_LEVEL_O) && $stable(CH3_LEVEL_O);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps) else $error("Level changed during sleep");

    property p_shutdown_clears;
        (CE_I && SHUTDOWN_I) |=> (CH2_LEVEL_O == 5'h00) && (CH3_LEVEL_O == 5'h00) && !CONV_EN_O && !SDA_OE_O;
    endproperty
    a_shutdown_clears: assert property (p_shutdown_clears) else $error("Shutdown kept configuration");

    property p_boot_sleep;
        $past(RST_I) |-> !CONV_EN_O && !CH2_DRIVE_EN_O && !CH3_DRIVE_EN_O;
    endproperty
    a_boot_sleep: assert property (p_boot_sleep) else $error("Converting right after reset");

    property p_idle_quiet;
        (CE_I && bus_stop && !SHUTDOWN_I) |=> (st_r == CDI_ST_IDLE) ##1 !SDA_OE_O;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("Data line driven after stop");

    c_write:    cover property (CE_I && wr_stb);
    c_read:     cover property (ld_first);
    c_shutdown: cover property (CE_I && SHUTDOWN_I ##1 !SHUTDOWN_I);
    c_active:   cover property ($rose(CONV_EN_O));
endmodule

/* dv/cdi_host_model.sv */
`timescale 1ns/1ps
`include "cdi_map.svh"

module cdi_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus conditions; data moves only while the clock is low
    task automatic start();
        @(negedge clk_i);
        sda_low_o = 1'b0;
        repeat (2) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (3) @(negedge clk_i);
        sda_low_o = 1'b1;
        repeat (3) @(negedge clk_i);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        @(negedge clk_i);
        sda_low_o = 1'b1;
        repeat (2) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (3) @(negedge clk_i);
        sda_low_o = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic bit_io(input logic b, output logic r);
        @(negedge clk_i);
        sda_low_o = ~b;
        repeat (2) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (3) @(negedge clk_i);
        r = sda_i;
        @(negedge clk_i);
        scl_o = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            r[i] = b;
        end
        bit_io(last, b);
        ack = ~b;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Single 16-bit register write and read, high byte first
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, output logic ack);
        logic [7:0] r;
        logic       k;
        start();
        xfer({a, 1'b0}, 1'b1, r, ack);
        xfer(p, 1'b1, r, k);
        xfer(d[15:8], 1'b1, r, k);
        xfer(d[7:0], 1'b1, r, k);
        stop();
    endtask

    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        logic k;
        start();
        xfer({`CDI_I2C_ADDR, 1'b0}, 1'b1, d[7:0], k);
        xfer(p, 1'b1, d[7:0], k);
        start();
        xfer({`CDI_I2C_ADDR, 1'b1}, 1'b1, d[7:0], k);
        xfer(8'hFF, 1'b0, d[15:8], k);
        xfer(8'hFF, 1'b1, d[7:0], k);
        stop();
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`include "cdi_map.svh"

module tb;
    import cdi_pkg::*;
    localparam logic [15:0] MAKER = 16'hA5C3; // Arbitrary value
    localparam logic [15:0] PART  = 16'h0101; // Arbitrary value
    localparam logic [15:0] PART_W = 16'h0202; // Arbitrary value
    typedef struct packed {
        logic [7:0]  ptr;
        logic [15:0] wd;
        logic [15:0] exp;
        logic [4:0]  l2;
        logic [4:0]  l3;
    } cdi_row_s;
    cdi_row_s rows [7] = '{
        '{8'h20, 16'hF800, 16'hF800, 5'h1F, 5'h00},
        '{8'h21, 16'hFFFF, 16'hF800, 5'h1F, 5'h1F},
        '{8'h20, 16'h07FF, 16'h0000, 5'h00, 5'h1F},
        '{8'h20, 16'h7FFF, 16'h7800, 5'h0F, 5'h1F},
        '{8'h7E, 16'h1234, MAKER,    5'h0F, 5'h1F},
        '{8'h7F, 16'hFFFF, PART,     5'h0F, 5'h1F},
        '{8'h14, 16'h2001, 16'h0000, 5'h0F, 5'h1F}};
    logic       clk, rst, shut, act, b2, b3, scl, sda, host_low, sda_o, sda_oe, ack;
    logic       de2, de3, conv;
    logic [15:0] rv;
    cdi_level_t l2, l3;
    int         n_fail, checks_done;
    logic       ce, oe_w;
    logic [18:0] w_bits;

    assign sda = ~(host_low | (sda_oe & ~sda_o));

    cdi_regs #(.MAKER_CODE(MAKER), .PART_CODE_N(PART), .PART_CODE_W(PART_W), .WIDE_PART(1'b0)) u_dut (
        .CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .SHUTDOWN_I(shut), .ACTIVE_CMD_I(act), .CH2_BUSY_I(b2), .CH3_BUSY_I(b3),
        .CH2_LEVEL_O(l2), .CH3_LEVEL_O(l3), .CH2_DRIVE_EN_O(de2), .CH3_DRIVE_EN_O(de3), .CONV_EN_O(conv));

    // Wide variant follows the bus but never drives it; its answer bits are recorded and checked by wide_rd after each read of the row loop
    cdi_regs #(.MAKER_CODE(MAKER), .PART_CODE_N(PART), .PART_CODE_W(PART_W), .WIDE_PART(1'b1)) u_dut_wide (
        .CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE_O(oe_w), .SHUTDOWN_I(shut), .ACTIVE_CMD_I(act), .CH2_BUSY_I(b2), .CH3_BUSY_I(b3),
        .CH2_LEVEL_O(), .CH3_LEVEL_O(), .CH2_DRIVE_EN_O(), .CH3_DRIVE_EN_O(), .CONV_EN_O());

    always @(posedge scl) begin
        w_bits <= {w_bits[17:0], ~oe_w};
    end

    cdi_host_model u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, ce, shut, act, b2, b3} = 6'b110000;
        cyc(3);
        rst = 1'b0;
        cyc(2);
        chk("conv_en", {15'h0, conv}, 16'h0000);
        foreach (rows[i]) begin
            u_host.wr(`CDI_I2C_ADDR, rows[i].ptr, rows[i].wd, ack);
            chk("ack", {15'h0, ack}, 16'h0001);
            chk("level2", {11'h0, l2}, {11'h0, rows[i].l2});
            chk("level3", {11'h0, l3}, {11'h0, rows[i].l3});
            u_host.rd(rows[i].ptr, rv);
            chk("readback", rv, rows[i].exp);
            chk("wide_rd", {w_bits[18:11], w_bits[9:2]}, (rows[i].ptr == 8'h7F) ? PART_W : rows[i].exp);
        end
        // Excitation only while converting in active mode
        act = 1'b1;
        b2  = 1'b1;
        cyc(3);
        chk("drive_en", {14'h0, de2, de3}, 16'h0002);
        chk("conv_en", {15'h0, conv}, 16'h0001);
        b2 = 1'b0;
        b3 = 1'b1;
        cyc(1);
        chk("drive_en", {14'h0, de2, de3}, 16'h0001);
        act = 1'b0;
        cyc(3);
        chk("drive_en", {13'h0, de2, de3, conv}, 16'h0000);
        // Sleep keeps contents
        cyc(20);
        u_host.rd(8'h20, rv);
        chk("sleep_keep", rv, 16'h7800);
        // Foreign target address is not answered
        u_host.wr(7'h2B, 8'h20, 16'hF800, ack);
        chk("bad_addr", {10'h0, ack, l2}, 16'h000F);
        // Clock enable low freezes all state, shutdown included
        ce   = 1'b0;
        shut = 1'b1;
        cyc(3);
        chk("ce_freeze", {l2, l3, 6'h00}, 16'h7FC0);
        // Shutdown drops configuration, host reprograms
        ce = 1'b1;
        cyc(3);
        chk("shut_lvl", {l2, l3, 5'h0, conv}, 16'h0000);
        shut = 1'b0;
        cyc(2);
        u_host.rd(8'h21, rv);
        chk("shut_rd", rv, 16'h0000);
        u_host.wr(`CDI_I2C_ADDR, 8'h21, 16'h7800, ack);
        chk("reprog", {11'h0, l3}, 16'h000F);
        // Mid-run reset
        rst = 1'b1;
        act = 1'b1;
        cyc(3);
        chk("rst_lvl", {l2, l3, 5'h0, conv}, 16'h0000);
        rst = 1'b0;
        act = 1'b0;
        cyc(2);
        u_host.rd(8'h20, rv);
        chk("rst_rd", rv, 16'h0000);
        give_verdict();
    end
endmodule
